//--- core/ubc_pkg.sv
// Package for the baud control block: register map, bit fields, reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses on word boundaries.
package ubc_pkg;
  // Register byte offsets
  localparam logic [4:0] UBC_OFS_BAUD_CONTROL = 5'h00;
  localparam logic [4:0] UBC_OFS_DIV_LOW      = 5'h04;
  localparam logic [4:0] UBC_OFS_DIV_HIGH     = 5'h08;
  localparam logic [4:0] UBC_OFS_PORT_MODE    = 5'h0C;
  // Field positions in baud_control, and the sync bit of the port mode register
  localparam int UBC_BIT_ROLLOVER = 7;
  localparam int UBC_BIT_RX_IDLE  = 6;
  localparam int UBC_BIT_RX_POL   = 5;
  localparam int UBC_BIT_TX_POL   = 4;
  localparam int UBC_BIT_DIV16    = 3;
  localparam int UBC_BIT_WAKE     = 1;
  localparam int UBC_BIT_ABD      = 0;
  localparam int UBC_BIT_SYNC     = 0;
  // Writable bits of baud_control; bit 2 and the status bit 6 take no write
  localparam logic [7:0] UBC_WR_MASK    = 8'hBB;
  localparam logic [7:0] UBC_CTRL_RESET = 8'h00;
  localparam logic [7:0] UBC_BYTE_RESET = 8'h00;
  // Auto-baud: four more falling edges after the start bit span eight bit times
  localparam logic [2:0]  UBC_ABD_FALLS = 3'h4;
  localparam int          UBC_ABD_SHIFT = 3;
  localparam logic [15:0] UBC_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] UBC_CNT_ONE   = 16'h0001;
  localparam logic [15:0] UBC_CNT_ZERO  = 16'h0000;

  typedef enum logic [2:0] {
    UBC_ABD_IDLE = 3'b001,
    UBC_ABD_WAIT = 3'b010,
    UBC_ABD_MEAS = 3'b100
  } ubc_abd_state_type;
endpackage

//--- core/ubc_baud_control.sv
// Baud control register of a serial port, with baud divisor, wake-up and auto-baud logic.
// Assumes a classic Wishbone master, and receive/transmit engines outside that use the pins and tick.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ubc_baud_control
  import ubc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Serial pins and engines
  input  wire logic        rx_pin_i,
  input  wire logic        rx_active_i,
  input  wire logic        tx_raw_i,
  input  wire logic        sclk_raw_i,
  output logic             rx_data_o,
  output logic             tx_pin_o,
  output logic             sclk_o,
  output logic             baud_tick_o,
  output logic             wake_irq_o
);
  import ubc_pkg::*;

  function automatic logic [15:0] eff_divisor(input logic wide, input logic [7:0] hi, input logic [7:0] lo);
    eff_divisor = wide ? {hi, lo} : {8'h00, lo};
  endfunction

  logic [7:0]        ctrl_q;
  logic [7:0]        div_lo_q;
  logic [7:0]        div_hi_q;
  logic              sync_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              rx_q;
  logic              rx_prev_q;
  logic              tx_q;
  logic              sclk_q;
  logic [15:0]       brg_q;
  logic              tick_q;
  logic              wake_armed_q;
  logic              wake_irq_q;
  logic [15:0]       abd_cnt_q;
  logic [2:0]        abd_falls_q;
  ubc_abd_state_type abd_q;
  logic              wr_en;
  logic              rx_fall;
  logic              rx_rise;
  logic              abd_done;
  logic              abd_ovf;
  logic              rx_idle;
  logic [15:0]       abd_div;
  logic [7:0]        ctrl_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, then a one-cycle ack
  assign wr_en = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  assign rx_idle   = !rx_active_i && (abd_q != UBC_ABD_MEAS);
  assign ctrl_view = {ctrl_q[7], rx_idle, ctrl_q[5:3], 1'b0, ctrl_q[1:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_q && !we_i) begin
      case (adr_i)
        UBC_OFS_BAUD_CONTROL: dat_q <= {24'h00_0000, ctrl_view};
        UBC_OFS_DIV_LOW:      dat_q <= {24'h00_0000, div_lo_q};
        UBC_OFS_DIV_HIGH:     dat_q <= {24'h00_0000, div_hi_q};
        UBC_OFS_PORT_MODE:    dat_q <= {31'h0000_0000, sync_q};
        default:              dat_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register; hardware sets beat a software clear of the rollover flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= UBC_CTRL_RESET;
    end else begin
      if (wr_en && adr_i == UBC_OFS_BAUD_CONTROL) begin
        ctrl_q <= dat_i[7:0] & UBC_WR_MASK;
      end else begin
        if (rx_rise && wake_armed_q && !sync_q) begin
          ctrl_q[UBC_BIT_WAKE] <= 1'b0;
        end
        if (abd_done || abd_ovf) begin
          ctrl_q[UBC_BIT_ABD] <= 1'b0;
        end
      end
      if (abd_ovf) begin
        ctrl_q[UBC_BIT_ROLLOVER] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
    end else if (wr_en && adr_i == UBC_OFS_PORT_MODE) begin
      sync_q <= dat_i[UBC_BIT_SYNC];
    end
  end

  // A finished measurement loads the divisor pair; a software write wins
  assign abd_div = abd_cnt_q >> UBC_ABD_SHIFT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_lo_q <= UBC_BYTE_RESET;
    end else if (wr_en && adr_i == UBC_OFS_DIV_LOW) begin
      div_lo_q <= dat_i[7:0];
    end else if (abd_done) begin
      div_lo_q <= abd_div[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_hi_q <= UBC_BYTE_RESET;
    end else if (wr_en && adr_i == UBC_OFS_DIV_HIGH) begin
      div_hi_q <= dat_i[7:0];
    end else if (abd_done) begin
      div_hi_q <= abd_div[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin polarity; all pins pass through one flip-flop
  // Hazard: flipping the receive polarity on an idle line makes a false edge;
  // set polarity before arming wake-up or auto-baud
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_q      <= 1'b1;
      rx_prev_q <= 1'b1;
      tx_q      <= 1'b1;
      sclk_q    <= 1'b0;
    end else begin
      rx_q      <= rx_pin_i ^ (ctrl_q[UBC_BIT_RX_POL] && !sync_q);
      rx_prev_q <= rx_q;
      tx_q      <= tx_raw_i ^ (ctrl_q[UBC_BIT_TX_POL] && !sync_q);
      sclk_q    <= sclk_raw_i ^ (ctrl_q[UBC_BIT_TX_POL] && sync_q);
    end
  end

  assign rx_data_o = rx_q;
  assign tx_pin_o  = tx_q;
  assign sclk_o    = sclk_q;
  assign rx_fall   = rx_prev_q && !rx_q;
  assign rx_rise   = !rx_prev_q && rx_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Baud generator; a divisor write restarts the count at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brg_q  <= UBC_CNT_ZERO;
      tick_q <= 1'b0;
    end else if (wr_en && (adr_i == UBC_OFS_DIV_LOW || adr_i == UBC_OFS_DIV_HIGH)) begin
      brg_q  <= UBC_CNT_ZERO;
      tick_q <= 1'b0;
    end else if (brg_q == UBC_CNT_ZERO) begin
      brg_q  <= eff_divisor(ctrl_q[UBC_BIT_DIV16], div_hi_q, div_lo_q);
      tick_q <= 1'b1;
    end else begin
      brg_q  <= brg_q - UBC_CNT_ONE;
      tick_q <= 1'b0;
    end
  end

  assign baud_tick_o = tick_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up: falling edge raises the interrupt, the next rising edge disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_armed_q <= 1'b0;
      wake_irq_q   <= 1'b0;
    end else begin
      wake_irq_q <= 1'b0;
      if (!ctrl_q[UBC_BIT_WAKE] || sync_q) begin
        wake_armed_q <= 1'b0;
      end else if (rx_fall && !wake_armed_q) begin
        wake_armed_q <= 1'b1;
        wake_irq_q   <= 1'b1;
      end else if (rx_rise) begin
        wake_armed_q <= 1'b0;
      end
    end
  end

  assign wake_irq_o = wake_irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Auto-baud: count clocks from the start edge to the fifth falling edge of 55h
  assign abd_done = (abd_q == UBC_ABD_MEAS) && rx_fall && (abd_falls_q == UBC_ABD_FALLS - 3'h1);
  assign abd_ovf  = (abd_q == UBC_ABD_MEAS) && (abd_cnt_q == UBC_CNT_MAX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abd_q       <= UBC_ABD_IDLE;
      abd_cnt_q   <= UBC_CNT_ZERO;
      abd_falls_q <= 3'h0;
    end else begin
      case (abd_q)
        UBC_ABD_IDLE: begin
          if (ctrl_q[UBC_BIT_ABD] && !sync_q) begin
            abd_q <= UBC_ABD_WAIT;
          end
        end
        UBC_ABD_WAIT: begin
          abd_cnt_q   <= UBC_CNT_ZERO;
          abd_falls_q <= 3'h0;
          if (!ctrl_q[UBC_BIT_ABD] || sync_q) begin
            abd_q <= UBC_ABD_IDLE;
          end else if (rx_fall) begin
            abd_q <= UBC_ABD_MEAS;
          end
        end
        UBC_ABD_MEAS: begin
          abd_cnt_q <= abd_cnt_q + UBC_CNT_ONE;
          if (abd_done || abd_ovf || !ctrl_q[UBC_BIT_ABD] || sync_q) begin
            abd_q <= UBC_ABD_IDLE;
          end else if (rx_fall) begin
            abd_falls_q <= abd_falls_q + 3'h1;
          end
        end
        default: abd_q <= UBC_ABD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_idle_flag_read: assert property (ctrl_view[UBC_BIT_RX_IDLE] == (!rx_active_i && abd_q != UBC_ABD_MEAS))
    else $error("Receiver idle flag wrong");
  chk_rx_polarity: assert property (##1 rx_q == ($past(rx_pin_i) ^ $past(ctrl_q[UBC_BIT_RX_POL] && !sync_q)))
    else $error("Receive polarity wrong");
  chk_tx_idle_level: assert property ($past(!sync_q && tx_raw_i) |-> tx_q == !$past(ctrl_q[UBC_BIT_TX_POL]))
    else $error("Transmit idle level wrong");
  chk_sclk_idle_level: assert property ($past(sync_q && !sclk_raw_i) |-> sclk_q == $past(ctrl_q[UBC_BIT_TX_POL]))
    else $error("Serial clock idle level wrong");
  chk_div_reload: assert property (brg_q == UBC_CNT_ZERO && !wr_en |=>
      brg_q == eff_divisor($past(ctrl_q[UBC_BIT_DIV16]), $past(div_hi_q), $past(div_lo_q)))
    else $error("Divisor reload wrong");
  chk_div8_ignores_high: assert property (brg_q == UBC_CNT_ZERO && !wr_en && !ctrl_q[UBC_BIT_DIV16] |=>
      brg_q[15:8] == 8'h00)
    else $error("High byte used in 8-bit mode");
  chk_wake_irq: assert property (wake_irq_q |-> $past(rx_fall && ctrl_q[UBC_BIT_WAKE] && !sync_q))
    else $error("Wake interrupt without cause");
  chk_wake_clear: assert property (wake_armed_q && rx_rise && !sync_q && !wr_en |=> !ctrl_q[UBC_BIT_WAKE])
    else $error("Wake enable not cleared");
  chk_abd_clear: assert property (abd_done && !wr_en |=> !ctrl_q[UBC_BIT_ABD] && abd_q == UBC_ABD_IDLE)
    else $error("Auto-baud enable not cleared");
  chk_rollover_set: assert property (abd_ovf |=> ctrl_q[UBC_BIT_ROLLOVER])
    else $error("Rollover flag not set");
  chk_bit2_zero: assert property (ack_q && $past(adr_i == UBC_OFS_BAUD_CONTROL && !we_i) |-> dat_o[2] == 1'b0)
    else $error("Bit 2 not zero");
  chk_ack_single: assert property (ack_q |=> !ack_q)
    else $error("Ack held");
  chk_ack_follows: assert property (cyc_i && stb_i && !ack_q |=> ack_q)
    else $error("Ack missing");
  chk_dat_hold: assert property (!(cyc_i && stb_i && !ack_q && !we_i) |=> $stable(dat_q))
    else $error("Read data moved");

  // Mode gating and self-clearing bits
  chk_wake_sync_quiet: assert property (sync_q |=> !wake_irq_q)
    else $error("Wake interrupt in sync mode");
  chk_wake_sync_keep: assert property (sync_q && ctrl_q[UBC_BIT_WAKE] && !wr_en |=> ctrl_q[UBC_BIT_WAKE])
    else $error("Wake enable cleared in sync mode");
  chk_wake_once: assert property (wake_armed_q |=> !wake_irq_q)
    else $error("Second wake interrupt");
  chk_wake_disarm: assert property (wake_armed_q && rx_rise && ctrl_q[UBC_BIT_WAKE] && !sync_q
      |=> !wake_armed_q)
    else $error("Wake not disarmed");
  chk_rollover_hold: assert property (ctrl_q[UBC_BIT_ROLLOVER] && !(wr_en && adr_i == UBC_OFS_BAUD_CONTROL)
      |=> ctrl_q[UBC_BIT_ROLLOVER])
    else $error("Rollover flag lost");
  chk_rollover_clear: assert property (wr_en && adr_i == UBC_OFS_BAUD_CONTROL && !dat_i[UBC_BIT_ROLLOVER]
      && !abd_ovf |=> !ctrl_q[UBC_BIT_ROLLOVER])
    else $error("Rollover flag not cleared");
  chk_abd_sync_idle: assert property (sync_q |=> abd_q != UBC_ABD_MEAS)
    else $error("Auto-baud runs in sync mode");
  chk_abd_start: assert property (abd_q == UBC_ABD_WAIT && rx_fall && ctrl_q[UBC_BIT_ABD] && !sync_q
      |=> abd_q == UBC_ABD_MEAS)
    else $error("Auto-baud did not start");
  chk_abd_ovf_idle: assert property (abd_ovf && !wr_en |=> abd_q == UBC_ABD_IDLE && !ctrl_q[UBC_BIT_ABD])
    else $error("Auto-baud not stopped on rollover");
  chk_abd_load_div: assert property (abd_done && !wr_en |=> {div_hi_q, div_lo_q} == $past(abd_div))
    else $error("Measured divisor not loaded");
  chk_div_restart: assert property (wr_en && (adr_i == UBC_OFS_DIV_LOW || adr_i == UBC_OFS_DIV_HIGH)
      |=> brg_q == UBC_CNT_ZERO)
    else $error("Divisor write did not restart");
  chk_bit2_store: assert property (!ctrl_q[2])
    else $error("Bit 2 stored");
  chk_idle_during_meas: assert property (abd_q == UBC_ABD_MEAS |-> !ctrl_view[UBC_BIT_RX_IDLE])
    else $error("Idle during measurement");
  chk_idle_readonly: assert property (!ctrl_q[UBC_BIT_RX_IDLE])
    else $error("Idle flag stored");
  chk_rx_sync_pass: assert property (sync_q |=> rx_q == $past(rx_pin_i))
    else $error("Receive inverted in sync mode");
  chk_tx_sync_pass: assert property (sync_q |=> tx_q == $past(tx_raw_i))
    else $error("Transmit inverted in sync mode");
  chk_sclk_async_pass: assert property (!sync_q |=> sclk_q == $past(sclk_raw_i))
    else $error("Clock inverted in async mode");

  cov_wake: cover property (wake_irq_q ##[1:1000] !ctrl_q[UBC_BIT_WAKE]);
  cov_abd_done: cover property (abd_done);
  cov_rollover: cover property (abd_ovf);
  cov_div16_tick: cover property (tick_q && ctrl_q[UBC_BIT_DIV16]);
  cov_sync_sclk: cover property (sync_q && sclk_q);
endmodule // ubc_baud_control

//--- sim/ubc_remote_node.sv
// Far-end serial sender that drives the receive pin of the baud control block.
// Assumes the testbench commands one frame or one line break at a time.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ubc_remote_node #(
  parameter int BIT_CLKS = 16
) (
  // Clock and commands
  input  wire logic clk_i,
  input  wire logic send_i,
  input  wire logic brk_i,
  // Line to the device
  output logic      rx_pin_o,
  output logic      rx_active_o
);
  logic [9:0] frame_q;
  int         bits_q;
  int         cnt_q;

  initial begin
    rx_pin_o    = 1'b1;
    rx_active_o = 1'b0;
    bits_q      = 0;
    cnt_q       = 0;
  end

  // Line idles high between frames; a break simply pulls it low
  always @(posedge clk_i) begin
    if (bits_q == 0) begin
      rx_active_o <= 1'b0;
      rx_pin_o    <= !brk_i;
      if (send_i) begin
        frame_q     <= {1'b1, 8'h55, 1'b0};
        bits_q      <= 10;
        cnt_q       <= 0;
        rx_active_o <= 1'b1;
      end
    end else begin
      rx_pin_o <= frame_q[0];
      if (cnt_q == BIT_CLKS - 1) begin
        cnt_q   <= 0;
        frame_q <= frame_q >> 1;
        bits_q  <= bits_q - 1;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule // ubc_remote_node

//--- sim/test_uart_baud_control_bits.sv
// Self-checking bench for the baud control block with a remote sender model.
// Assumes the one-cycle Wishbone answer and registered pins of the design.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s expected %0h seen %0h", n, e, g); end end

////////////////////////////////////////////////////////////////////////////////
module test_uart_baud_control_bits;
  import ubc_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, rx_pin_i, rx_active_i, tx_raw_i = 1, sclk_raw_i = 0;
  logic        rx_data_o, tx_pin_o, sclk_o, baud_tick_o, wake_irq_o;
  logic        send = 0, brk = 0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [7:0]  lo, hi;
  int          seed = 32'h89ad, errors = 0, tests_run = 0, cycles = 0, wake_cnt = 0;

  always #5 clk_i = ~clk_i;

  ubc_baud_control ubc_baud_control_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_pin_i(rx_pin_i), .rx_active_i(rx_active_i), .tx_raw_i(tx_raw_i), .sclk_raw_i(sclk_raw_i),
    .rx_data_o(rx_data_o), .tx_pin_o(tx_pin_o), .sclk_o(sclk_o), .baud_tick_o(baud_tick_o),
    .wake_irq_o(wake_irq_o));
  ubc_remote_node #(.BIT_CLKS(16)) ubc_remote_node_inst (.clk_i(clk_i), .send_i(send), .brk_i(brk),
    .rx_pin_o(rx_pin_i), .rx_active_o(rx_active_i));

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Rollover scenario alone needs about 65.6k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (wake_irq_o === 1'b1) wake_cnt++;
    if (cycles > 80000) begin
      errors++;
      summarize();
    end
  end

  // Read data is compared against the oldest note at the acknowledging edge
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK("read", exp_v, dat_o)
    end
  end

  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    {cyc_i, stb_i} <= 2'b00;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask

  task automatic period(input int e);
    int n;
    n = 0;
    do @(posedge clk_i); while (baud_tick_o !== 1'b1);
    do begin @(posedge clk_i); n++; end while (baud_tick_o !== 1'b1);
    `CHK("period", e, n)
  endtask

  task automatic pins(input logic ri, input logic ti, input logic ci);
    logic [1:0] r;
    r = $random(seed);
    {tx_raw_i, sclk_raw_i} <= r;
    repeat (3) @(posedge clk_i);
    `CHK("rx_data", rx_pin_i ^ ri, rx_data_o)
    `CHK("tx_pin", r[1] ^ ti, tx_pin_o)
    `CHK("sclk", r[0] ^ ci, sclk_o)
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(UBC_OFS_BAUD_CONTROL, 8'h40);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'hBC);
    rd(UBC_OFS_BAUD_CONTROL, 8'hF8);
    pins(1'b1, 1'b1, 1'b0);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h00);
    rd(UBC_OFS_BAUD_CONTROL, 8'h40);
    pins(1'b0, 1'b0, 1'b0);
    rd(5'h10, 8'h00);
    lo = 8'h01 + ($random(seed) & 8'h07);
    hi = 8'h01 + ($random(seed) & 8'h01);
    wb(1'b1, UBC_OFS_DIV_LOW, lo);
    wb(1'b1, UBC_OFS_DIV_HIGH, hi);
    period(lo + 1);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h08);
    period({hi, lo} + 1);
    wb(1'b1, UBC_OFS_PORT_MODE, 8'h01);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h32);
    pins(1'b0, 1'b0, 1'b1);
    brk <= 1'b1;
    repeat (10) @(posedge clk_i);
    brk <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK("wake_sync", 0, wake_cnt)
    rd(UBC_OFS_BAUD_CONTROL, 8'h72);
    wb(1'b1, UBC_OFS_PORT_MODE, 8'h00);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h02);
    brk <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK("wake", 1, wake_cnt)
    brk <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(UBC_OFS_BAUD_CONTROL, 8'h40);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h01);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd(UBC_OFS_BAUD_CONTROL, 8'h01);
    repeat (200) @(posedge clk_i);
    rd(UBC_OFS_BAUD_CONTROL, 8'h40);
    rd(UBC_OFS_DIV_LOW, 8'h0F);
    rd(UBC_OFS_DIV_HIGH, 8'h00);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h01);
    brk <= 1'b1;
    repeat (65600) @(posedge clk_i);
    brk <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(UBC_OFS_BAUD_CONTROL, 8'hC0);
    wb(1'b1, UBC_OFS_BAUD_CONTROL, 8'h00);
    rd(UBC_OFS_BAUD_CONTROL, 8'h40);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule // test_uart_baud_control_bits
